/* File: logic/zlk_zone_lock.sv */
/*
 zone access policy and ephemeral key status flags for a secure element.
 assumes a command engine on the same clock: it reads o_grant combinationally
 and reports each finished command with i_done.
*/
// Contract
// - data/otp zones are unlocked only while the data lock byte is 0x55
// - data lock byte changes only by lock command and never returns to unlocked
// - before config lock every data or otp read and write is rejected
// - unlocked data zone: reads refused, writes accepted, slot policy mostly ignored
// - locked data zone: reads allowed, writes follow slot policy and otp mode; code grants otp reads only with i_otp_mode_ok
// - zero mask bit after config lock forbids write, private write, keygen, derive
// - zero mask bit rejects writes even while the data zone is unlocked
// - slot lock clears mask bit only when mask and permit bits are both one
// - before config lock, mask and permit bits are freely writable
// - slot locking performs no crc check of slot contents
// - verify on a slot is allowed whatever its mask bit
// - sleep or power loss invalidates the working ram and the ephemeral key
// - key value never leaves; only nine flag bits, only via status query
// - digest and keygen update the key; challenge and mac-check copy replace it
// - four-bit source slot recorded for digest-generate and key-generate
// - random source flag is 0 for internal random, 1 for seed only
// - digest and keygen origin flags set for those producers, else zero
// - mac-forbid flag set from any source slot; mac command refuses key only in hmac mode
// - valid bit cleared on power-up, sleep, brown-out, watchdog, tamper
// - idle mode leaves key contents and valid bit unchanged
// - challenge, keygen, digest clear valid on errors other than crc or ecc retry
// - mac-check clears valid unless copy succeeds; status never; others on any result other than crc or ecc retry, success included
`timescale 1ns/1ps
`include "zlk_cfg.svh"

module zlk_zone_lock #(
    parameter int SLOTS = 16,
    parameter int KEY_W = 256
) (
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    // policy check request from the command engine
    input  wire logic               i_chk_valid,
    input  zlk_pkg::zlk_cmd_e       i_chk_cmd,
    input  zlk_pkg::zlk_zone_e      i_chk_zone,
    input  wire logic [3:0]         i_chk_slot,
    input  wire logic               i_slot_policy_ok,
    input  wire logic               i_otp_mode_ok,
    input  wire logic               i_hmac_mode,
    output logic                    o_grant,
    // config writes before config lock
    input  wire logic               i_cfg_mask_we,
    input  wire logic [SLOTS-1:0]   i_cfg_mask_wdata,
    input  wire logic               i_cfg_permit_we,
    input  wire logic [SLOTS-1:0]   i_cfg_permit_wdata,
    // command completion
    input  wire logic               i_done,
    input  zlk_pkg::zlk_cmd_e       i_done_cmd,
    input  zlk_pkg::zlk_res_e       i_done_res,
    input  wire logic [3:0]         i_done_slot,
    input  wire logic               i_done_rand_internal,
    input  wire logic               i_done_mac_forbid,
    input  wire logic [KEY_W-1:0]   i_done_key,
    // power events
    input  wire logic               i_sleep,
    input  wire logic               i_brownout,
    input  wire logic               i_wdog,
    input  wire logic               i_tamper,
    // status
    output logic                    o_data_unlocked,
    output logic                    o_cfg_unlocked,
    output logic [SLOTS-1:0]        o_slot_lock_mask,
    output logic [SLOTS-1:0]        o_slot_lock_permit,
    output logic [`ZLK_FLAGS_W-1:0] o_status_flags,
    output logic                    o_status_valid,
    output logic [KEY_W-1:0]        o_key_internal
);

    logic [7:0]              data_lock_q;
    logic [7:0]              data_lock_d;
    logic [7:0]              cfg_lock_q;
    logic [7:0]              cfg_lock_d;
    logic [SLOTS-1:0]        mask_q;
    logic [SLOTS-1:0]        mask_d;
    logic [SLOTS-1:0]        permit_q;
    logic [SLOTS-1:0]        permit_d;
    logic [KEY_W-1:0]        key_q;
    logic [KEY_W-1:0]        key_d;
    logic [3:0]              src_slot_q;
    logic [3:0]              src_slot_d;
    logic                    rand_src_q;
    logic                    rand_src_d;
    logic                    dig_org_q;
    logic                    dig_org_d;
    logic                    kg_org_q;
    logic                    kg_org_d;
    logic                    mac_forbid_q;
    logic                    mac_forbid_d;
    logic                    valid_q;
    logic                    valid_d;
    logic [`ZLK_FLAGS_W-1:0] flags_q;
    logic [`ZLK_FLAGS_W-1:0] flags_d;
    logic                    stat_vld_q;
    logic                    stat_vld_d;

    logic cfg_unlocked;
    logic data_unlocked;
    logic slot_open;
    logic soft_err;
    logic done_ok;

    assign cfg_unlocked  = (cfg_lock_q == `ZLK_UNLOCKED_VAL);
    assign data_unlocked = (data_lock_q == `ZLK_UNLOCKED_VAL);
    assign slot_open     = mask_q[i_chk_slot];
    assign soft_err      = (i_done_res == zlk_pkg::ZLK_RES_CRC) ||
                           (i_done_res == zlk_pkg::ZLK_RES_ECC_RTY);
    assign done_ok       = (i_done_res == zlk_pkg::ZLK_RES_OK);

    // combinational so the engine sees it in the request cycle
    always_comb
    begin
        o_grant = 1'b0;
        if (i_chk_valid)
        begin
            unique case (i_chk_cmd)
                zlk_pkg::ZLK_CMD_READ:
                begin
                    if (i_chk_zone == zlk_pkg::ZLK_ZONE_CFG)
                        o_grant = 1'b1;
                    else if (cfg_unlocked)
                        o_grant = 1'b0;
                    else if (data_unlocked)
                        o_grant = 1'b0;
                    else
                        o_grant = (i_chk_zone != zlk_pkg::ZLK_ZONE_OTP) ||
                                  i_otp_mode_ok;
                end
                zlk_pkg::ZLK_CMD_WRITE,
                zlk_pkg::ZLK_CMD_PRIV_WR,
                zlk_pkg::ZLK_CMD_KEYGEN,
                zlk_pkg::ZLK_CMD_DERIVE:
                begin
                    if (i_chk_zone == zlk_pkg::ZLK_ZONE_CFG)
                        o_grant = cfg_unlocked && (i_chk_cmd == zlk_pkg::ZLK_CMD_WRITE);
                    else if (cfg_unlocked)
                        o_grant = 1'b0;
                    else if (i_chk_zone == zlk_pkg::ZLK_ZONE_OTP)
                        o_grant = data_unlocked || i_otp_mode_ok;
                    else if (!slot_open)
                        o_grant = 1'b0;
                    else if (data_unlocked)
                        o_grant = 1'b1;
                    else
                        o_grant = i_slot_policy_ok;
                end
                zlk_pkg::ZLK_CMD_VERIFY:
                    o_grant = 1'b1;
                zlk_pkg::ZLK_CMD_MAC:
                    o_grant = valid_q && !(mac_forbid_q && i_hmac_mode);
                zlk_pkg::ZLK_CMD_LOCK_SLOT:
                    o_grant = !cfg_unlocked && mask_q[i_chk_slot] &&
                              permit_q[i_chk_slot];
                zlk_pkg::ZLK_CMD_LOCK_DATA:
                    o_grant = !cfg_unlocked && data_unlocked;
                zlk_pkg::ZLK_CMD_LOCK_CFG:
                    o_grant = cfg_unlocked;
                default:
                    o_grant = 1'b1;
            endcase
        end
    end

    // lock bytes and per-slot mask
    always_comb
    begin
        data_lock_d = data_lock_q;
        cfg_lock_d  = cfg_lock_q;
        mask_d      = mask_q;
        permit_d    = permit_q;
        if (cfg_unlocked)
        begin
            if (i_cfg_mask_we)
                mask_d = i_cfg_mask_wdata;
            if (i_cfg_permit_we)
                permit_d = i_cfg_permit_wdata;
        end
        if (i_done && done_ok)
        begin
            unique case (i_done_cmd)
                zlk_pkg::ZLK_CMD_LOCK_DATA:
                    if (!cfg_unlocked)
                        data_lock_d = `ZLK_LOCKED_VAL;
                zlk_pkg::ZLK_CMD_LOCK_CFG:
                    cfg_lock_d = `ZLK_LOCKED_VAL;
                zlk_pkg::ZLK_CMD_LOCK_SLOT:
                    // no content crc here: contents are checked at zone lock or by mac
                    if (!cfg_unlocked && mask_q[i_done_slot] && permit_q[i_done_slot])
                        mask_d[i_done_slot] = 1'b0;
                default:
                    mask_d = mask_d;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            data_lock_q <= `ZLK_LOCK_RST;
            cfg_lock_q  <= `ZLK_LOCK_RST;
            mask_q      <= SLOTS'(`ZLK_MASK_RST);
            permit_q    <= SLOTS'(`ZLK_PERMIT_RST);
        end
        else
        begin
            data_lock_q <= data_lock_d;
            cfg_lock_q  <= cfg_lock_d;
            mask_q      <= mask_d;
            permit_q    <= permit_d;
        end
    end

    // ephemeral key and its flags
    always_comb
    begin
        key_d        = key_q;
        src_slot_d   = src_slot_q;
        rand_src_d   = rand_src_q;
        dig_org_d    = dig_org_q;
        kg_org_d     = kg_org_q;
        mac_forbid_d = mac_forbid_q;
        valid_d      = valid_q;
        if (i_sleep || i_brownout || i_wdog || i_tamper)
        begin
            // sleep also zeroes the key but keeps its flags; the other events only drop valid
            valid_d = 1'b0;
            if (i_sleep)
                key_d = '0;
        end
        else if (i_done)
        begin
            unique case (i_done_cmd)
                zlk_pkg::ZLK_CMD_DIGEST,
                zlk_pkg::ZLK_CMD_KEYGEN:
                begin
                    if (done_ok)
                    begin
                        key_d        = i_done_key;
                        src_slot_d   = i_done_slot;
                        dig_org_d    = (i_done_cmd == zlk_pkg::ZLK_CMD_DIGEST);
                        kg_org_d     = (i_done_cmd == zlk_pkg::ZLK_CMD_KEYGEN);
                        mac_forbid_d = mac_forbid_q | i_done_mac_forbid;
                        valid_d      = 1'b1;
                    end
                    else if (!soft_err)
                        valid_d = 1'b0;
                end
                zlk_pkg::ZLK_CMD_CHALLENGE:
                begin
                    if (done_ok)
                    begin
                        key_d        = i_done_key;
                        rand_src_d   = !i_done_rand_internal;
                        dig_org_d    = 1'b0;
                        kg_org_d     = 1'b0;
                        mac_forbid_d = 1'b0;
                        valid_d      = 1'b1;
                    end
                    else if (!soft_err)
                        valid_d = 1'b0;
                end
                zlk_pkg::ZLK_CMD_MACCHK:
                begin
                    if (done_ok)
                    begin
                        key_d        = i_done_key;
                        dig_org_d    = 1'b0;
                        kg_org_d     = 1'b0;
                        mac_forbid_d = i_done_mac_forbid;
                        valid_d      = 1'b1;
                    end
                    else
                        valid_d = 1'b0;
                end
                zlk_pkg::ZLK_CMD_STATUS:
                    valid_d = valid_q;
                default:
                    if (!soft_err)
                        valid_d = 1'b0;
            endcase
        end
        // idle is simply the absence of events: nothing above fires
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            key_q        <= '0;
            src_slot_q   <= 4'h0;
            rand_src_q   <= 1'b0;
            dig_org_q    <= 1'b0;
            kg_org_q     <= 1'b0;
            mac_forbid_q <= 1'b0;
            valid_q      <= 1'b0;
        end
        else
        begin
            key_q        <= key_d;
            src_slot_q   <= src_slot_d;
            rand_src_q   <= rand_src_d;
            dig_org_q    <= dig_org_d;
            kg_org_q     <= kg_org_d;
            mac_forbid_q <= mac_forbid_d;
            valid_q      <= valid_d;
        end
    end

    // flags only, captured when a status query completes
    always_comb
    begin
        flags_d    = flags_q;
        stat_vld_d = 1'b0;
        if (i_done && (i_done_cmd == zlk_pkg::ZLK_CMD_STATUS))
        begin
            flags_d[`ZLK_F_SLOT_MSB:`ZLK_F_SLOT_LSB] = src_slot_q;
            flags_d[`ZLK_F_RANDSRC]   = rand_src_q;
            flags_d[`ZLK_F_DIGEST]    = dig_org_q;
            flags_d[`ZLK_F_KEYGEN]    = kg_org_q;
            flags_d[`ZLK_F_MACFORBID] = mac_forbid_q;
            flags_d[`ZLK_F_VALID]     = valid_q;
            stat_vld_d                = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            flags_q    <= '0;
            stat_vld_q <= 1'b0;
        end
        else
        begin
            flags_q    <= flags_d;
            stat_vld_q <= stat_vld_d;
        end
    end

    assign o_data_unlocked    = data_unlocked;
    assign o_cfg_unlocked     = cfg_unlocked;
    assign o_slot_lock_mask   = mask_q;
    assign o_slot_lock_permit = permit_q;
    assign o_status_flags     = flags_q;
    assign o_status_valid     = stat_vld_q;
    // internal use only by crypto datapath, never routed to a pin
    assign o_key_internal     = key_q;

endmodule : zlk_zone_lock

/* File: logic/zlk_cfg.svh */
/*
 lock values, reset values and field positions of the zone lock block.
 assumes inclusion by its design file and checker.
*/
`ifndef ZLK_CFG_SVH
`define ZLK_CFG_SVH

`define ZLK_UNLOCKED_VAL   8'h55
`define ZLK_LOCKED_VAL     8'h00
`define ZLK_LOCK_RST       8'h55
`define ZLK_MASK_RST       16'hffff
`define ZLK_PERMIT_RST     16'h0000
`define ZLK_FLAGS_W        9
`define ZLK_F_SLOT_LSB     0
`define ZLK_F_SLOT_MSB     3
`define ZLK_F_RANDSRC      4
`define ZLK_F_DIGEST       5
`define ZLK_F_KEYGEN       6
`define ZLK_F_MACFORBID    7
`define ZLK_F_VALID        8

`endif

/* File: logic/zlk_pkg.sv */
/*
 command, zone and outcome types of the zone lock block.
 assumes the command engine encodes its requests with these types.
*/
package zlk_pkg;

    typedef enum logic [3:0] {
        ZLK_CMD_READ      = 4'h0,
        ZLK_CMD_WRITE     = 4'h1,
        ZLK_CMD_PRIV_WR   = 4'h2,
        ZLK_CMD_KEYGEN    = 4'h3,
        ZLK_CMD_DERIVE    = 4'h4,
        ZLK_CMD_DIGEST    = 4'h5,
        ZLK_CMD_CHALLENGE = 4'h6,
        ZLK_CMD_MACCHK    = 4'h7,
        ZLK_CMD_STATUS    = 4'h8,
        ZLK_CMD_VERIFY    = 4'h9,
        ZLK_CMD_LOCK_DATA = 4'ha,
        ZLK_CMD_LOCK_CFG  = 4'hb,
        ZLK_CMD_LOCK_SLOT = 4'hc,
        ZLK_CMD_MAC       = 4'hd,
        ZLK_CMD_OTHER     = 4'he
    } zlk_cmd_e;

    typedef enum logic [1:0] {
        ZLK_ZONE_CFG  = 2'h0,
        ZLK_ZONE_DATA = 2'h1,
        ZLK_ZONE_OTP  = 2'h2
    } zlk_zone_e;

    typedef enum logic [1:0] {
        ZLK_RES_OK      = 2'h0,
        ZLK_RES_ERR     = 2'h1,
        ZLK_RES_CRC     = 2'h2,
        ZLK_RES_ECC_RTY = 2'h3
    } zlk_res_e;

endpackage : zlk_pkg

/* File: verif/zlk_zone_lock_props.sv */
/*
 port-view checker for zlk_zone_lock.
 assumes a bind from the bench top; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "zlk_cfg.svh"
module zlk_zone_lock_props #(
    parameter int SLOTS = 16
) (
    input wire logic                   i_clk,
    input wire logic                   i_rst_n,
    input wire logic                   i_chk_valid,
    input zlk_pkg::zlk_cmd_e           i_chk_cmd,
    input zlk_pkg::zlk_zone_e          i_chk_zone,
    input wire logic [3:0]             i_chk_slot,
    input wire logic                   o_grant,
    input wire logic                   i_cfg_mask_we,
    input wire logic [SLOTS-1:0]       i_cfg_mask_wdata,
    input wire logic                   i_done,
    input zlk_pkg::zlk_cmd_e           i_done_cmd,
    input zlk_pkg::zlk_res_e           i_done_res,
    input wire logic [3:0]             i_done_slot,
    input wire logic                   i_sleep,
    input wire logic                   i_brownout,
    input wire logic                   i_wdog,
    input wire logic                   i_tamper,
    input wire logic                   o_data_unlocked,
    input wire logic                   o_cfg_unlocked,
    input wire logic [SLOTS-1:0]       o_slot_lock_mask,
    input wire logic [SLOTS-1:0]       o_slot_lock_permit,
    input wire logic [`ZLK_FLAGS_W-1:0] o_status_flags,
    input wire logic                   o_status_valid
);
    wire logic pwr = i_sleep | i_brownout | i_wdog | i_tamper;
    wire logic st  = i_done && i_done_cmd == zlk_pkg::ZLK_CMD_STATUS;
    wire logic rd  = i_chk_cmd == zlk_pkg::ZLK_CMD_READ;
    wire logic wr  = i_chk_cmd == zlk_pkg::ZLK_CMD_WRITE;
    wire logic dz  = i_chk_zone == zlk_pkg::ZLK_ZONE_DATA;
    wire logic cz  = i_chk_zone == zlk_pkg::ZLK_ZONE_CFG;
    wire logic md  = i_chk_cmd inside {zlk_pkg::ZLK_CMD_WRITE, zlk_pkg::ZLK_CMD_PRIV_WR,
                                       zlk_pkg::ZLK_CMD_KEYGEN, zlk_pkg::ZLK_CMD_DERIVE};
    wire logic sl  = i_done && i_done_cmd == zlk_pkg::ZLK_CMD_LOCK_SLOT;
    wire logic dl  = i_done && i_done_cmd == zlk_pkg::ZLK_CMD_LOCK_DATA;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    AST_PRE_CFG: assert property (i_chk_valid && o_cfg_unlocked && (rd || wr) && !cz
        |-> !o_grant) else $error("zone access granted before config lock");
    AST_READ_UNLOCKED: assert property (i_chk_valid && rd && !cz && o_data_unlocked
        |-> !o_grant) else $error("read granted while data zone unlocked");
    AST_MASK_ZERO: assert property (i_chk_valid && md && dz
        && !o_slot_lock_mask[i_chk_slot] |-> !o_grant) else $error("locked slot modifiable");
    AST_VERIFY: assert property (i_chk_valid && i_chk_cmd == zlk_pkg::ZLK_CMD_VERIFY
        |-> o_grant) else $error("verify refused");
    AST_STICKY: assert property (!o_data_unlocked |=> !o_data_unlocked)
        else $error("data zone unlocked again");
    AST_LOCK_CMD: assert property (o_data_unlocked && !dl |=> o_data_unlocked)
        else $error("data lock byte moved without lock command");
    AST_SLOT_LOCK: assert property (sl && i_done_res == zlk_pkg::ZLK_RES_OK
        && !o_cfg_unlocked && o_slot_lock_permit[i_done_slot] && !pwr
        |=> !o_slot_lock_mask[$past(i_done_slot)]) else $error("slot lock not applied");
    AST_CFG_WRITE: assert property (i_cfg_mask_we && o_cfg_unlocked
        |=> o_slot_lock_mask == $past(i_cfg_mask_wdata)) else $error("mask write lost");
    AST_STATUS_ONLY: assert property (o_status_valid |-> $past(st))
        else $error("status flags without status query");
    AST_PWR_VALID: assert property (st && $past(pwr, 2) && !$past(i_done)
        |=> !o_status_flags[`ZLK_F_VALID]) else $error("key valid survived power event");
endmodule : zlk_zone_lock_props

/* File: verif/zlk_engine.sv */
/*
 command engine model: policy checks and command completion.
 assumes the bench calls its tasks; it drives only after a falling clock edge.
*/
`timescale 1ns/1ps
module zlk_engine (
    input  wire logic          i_clk,
    input  wire logic          i_grant,
    output logic               o_chk_valid,
    output zlk_pkg::zlk_cmd_e  o_chk_cmd,
    output zlk_pkg::zlk_zone_e o_chk_zone,
    output logic [3:0]         o_chk_slot,
    output logic               o_ok,
    output logic               o_done,
    output zlk_pkg::zlk_cmd_e  o_done_cmd,
    output zlk_pkg::zlk_res_e  o_done_res,
    output logic [3:0]         o_done_slot,
    output logic               o_rand_int,
    output logic               o_mac_forbid,
    output logic [255:0]       o_key
);
    initial
    begin
        o_chk_valid  = 1'b0;
        o_chk_cmd    = zlk_pkg::ZLK_CMD_OTHER;
        o_chk_zone   = zlk_pkg::ZLK_ZONE_CFG;
        o_chk_slot   = 4'h0;
        o_ok         = 1'b0;
        o_done       = 1'b0;
        o_done_cmd   = zlk_pkg::ZLK_CMD_OTHER;
        o_done_res   = zlk_pkg::ZLK_RES_OK;
        o_done_slot  = 4'h0;
        o_rand_int   = 1'b0;
        o_mac_forbid = 1'b0;
        o_key        = 256'h0;
    end
    // grant is combinational: read it once the fields settle
    task check(input zlk_pkg::zlk_cmd_e c, input zlk_pkg::zlk_zone_e z,
               input logic [3:0] s, input logic ok, output logic g);
        @(negedge i_clk);
        o_chk_valid = 1'b1;
        o_chk_cmd   = c;
        o_chk_zone  = z;
        o_chk_slot  = s;
        o_ok        = ok;
        #1;
        g = i_grant;
    endtask : check
    // one-cycle done; slot and key scrambled after so stale values never help
    task complete(input zlk_pkg::zlk_cmd_e c, input zlk_pkg::zlk_res_e r, input logic [3:0] s,
                  input logic ri, input logic mf, input logic [255:0] k);
        @(negedge i_clk);
        o_done       = 1'b1;
        o_done_cmd   = c;
        o_done_res   = r;
        o_done_slot  = s;
        o_rand_int   = ri;
        o_mac_forbid = mf;
        o_key        = k;
        @(negedge i_clk);
        o_done       = 1'b0;
        o_done_slot  = ~s;
        o_key        = ~k;
    endtask : complete
endmodule : zlk_engine

/* File: verif/test_zlk_zone_lock.sv */
/*
 self-checking bench for zlk_zone_lock.
 assumes the engine model in zlk_engine.sv and binds the port checker.
*/
`timescale 1ns/1ps
module test_zlk_zone_lock;
    logic               clk, rst_n, mwe, pwe, cv, ok, dn, ri, mf, gr, du, cu, sv, hm;
    logic [15:0]        mwd, pwd, msk, prm;
    logic [3:0]         ev, cs, ds;
    logic [8:0]         fl;
    logic [255:0]       kv, dk, ki;
    zlk_pkg::zlk_cmd_e  cc, dc;
    zlk_pkg::zlk_zone_e cz;
    zlk_pkg::zlk_res_e  dr;
    int                 errors, comparisons;
    zlk_zone_lock dut (.i_clk(clk), .i_rst_n(rst_n), .i_chk_valid(cv), .i_chk_cmd(cc),
        .i_chk_zone(cz), .i_chk_slot(cs), .i_slot_policy_ok(ok), .i_otp_mode_ok(ok),
        .i_hmac_mode(hm), .o_grant(gr), .i_cfg_mask_we(mwe), .i_cfg_mask_wdata(mwd),
        .i_cfg_permit_we(pwe), .i_cfg_permit_wdata(pwd), .i_done(dn), .i_done_cmd(dc),
        .i_done_res(dr), .i_done_slot(ds), .i_done_rand_internal(ri), .i_done_mac_forbid(mf),
        .i_done_key(dk), .i_sleep(ev[0]), .i_brownout(ev[1]), .i_wdog(ev[2]),
        .i_tamper(ev[3]), .o_data_unlocked(du), .o_cfg_unlocked(cu), .o_slot_lock_mask(msk),
        .o_slot_lock_permit(prm), .o_status_flags(fl), .o_status_valid(sv), .o_key_internal(ki));
    zlk_engine eng (.i_clk(clk), .i_grant(gr), .o_chk_valid(cv), .o_chk_cmd(cc),
        .o_chk_zone(cz), .o_chk_slot(cs), .o_ok(ok), .o_done(dn), .o_done_cmd(dc),
        .o_done_res(dr), .o_done_slot(ds), .o_rand_int(ri), .o_mac_forbid(mf), .o_key(dk));
    task cmp(input logic [255:0] g, input logic [255:0] e);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task finish_test;
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    task g(input zlk_pkg::zlk_cmd_e c, input logic [3:0] s, input logic k, input logic e,
           input logic otp = 1'b0);
        logic r;
        eng.check(c, otp ? zlk_pkg::ZLK_ZONE_OTP : zlk_pkg::ZLK_ZONE_DATA, s, k, r);
        cmp(r, e);
    endtask : g
    task d(input zlk_pkg::zlk_cmd_e c, input zlk_pkg::zlk_res_e r = zlk_pkg::ZLK_RES_OK,
           input logic [3:0] s = 4'h0, input logic rin = 1'b0, input logic mfb = 1'b0);
        eng.complete(c, r, s, rin, mfb, kv);
    endtask : d
    task q(input logic [8:0] e, input logic [8:0] m);
        d(zlk_pkg::ZLK_CMD_STATUS);
        cmp(sv, 1'b1);
        cmp(fl & m, e);
    endtask : q
    task cfg_wr(input logic [15:0] m, input logic [15:0] p);
        @(negedge clk);
        {mwe, pwe, mwd, pwd} = {2'b11, m, p};
        @(negedge clk);
        {mwe, pwe} = 2'b00;
    endtask : cfg_wr
    task t_pre_cfg;
        cmp({du, cu, msk, prm, fl}, {2'b11, 16'hffff, 16'h0000, 9'h000});
        g(zlk_pkg::ZLK_CMD_READ, 4'h1, 1'b1, 1'b0);
        g(zlk_pkg::ZLK_CMD_WRITE, 4'h1, 1'b1, 1'b0, 1'b1);
        cfg_wr(16'hfffe, 16'h0006);
        cmp({msk, prm}, {16'hfffe, 16'h0006});
        d(zlk_pkg::ZLK_CMD_LOCK_DATA);
        d(zlk_pkg::ZLK_CMD_LOCK_SLOT, zlk_pkg::ZLK_RES_OK, 4'h1);
        cmp({du, msk}, {1'b1, 16'hfffe});
    endtask : t_pre_cfg
    task t_cfg_locked;
        d(zlk_pkg::ZLK_CMD_LOCK_CFG);
        cfg_wr(16'h0000, 16'hffff);
        cmp({cu, msk, prm}, {1'b0, 16'hfffe, 16'h0006});
        g(zlk_pkg::ZLK_CMD_READ, 4'h1, 1'b1, 1'b0);
        g(zlk_pkg::ZLK_CMD_WRITE, 4'h1, 1'b0, 1'b1);
        g(zlk_pkg::ZLK_CMD_WRITE, 4'h0, 1'b1, 1'b0);
        g(zlk_pkg::ZLK_CMD_DERIVE, 4'h0, 1'b1, 1'b0);
        g(zlk_pkg::ZLK_CMD_VERIFY, 4'h0, 1'b0, 1'b1);
        d(zlk_pkg::ZLK_CMD_LOCK_SLOT, zlk_pkg::ZLK_RES_OK, 4'h3);
        d(zlk_pkg::ZLK_CMD_LOCK_SLOT, zlk_pkg::ZLK_RES_OK, 4'h2);
        cmp(msk, 16'hfffa);
        g(zlk_pkg::ZLK_CMD_PRIV_WR, 4'h2, 1'b1, 1'b0);
    endtask : t_cfg_locked
    task t_data_locked;
        d(zlk_pkg::ZLK_CMD_LOCK_DATA);
        cmp(du, 1'b0);
        g(zlk_pkg::ZLK_CMD_READ, 4'h1, 1'b1, 1'b1);
        g(zlk_pkg::ZLK_CMD_WRITE, 4'h1, 1'b0, 1'b0);
        g(zlk_pkg::ZLK_CMD_WRITE, 4'h1, 1'b1, 1'b1);
        g(zlk_pkg::ZLK_CMD_READ, 4'h1, 1'b0, 1'b0, 1'b1);
        d(zlk_pkg::ZLK_CMD_LOCK_SLOT, zlk_pkg::ZLK_RES_OK, 4'h1);
        cmp(msk, 16'hfff8);
    endtask : t_data_locked
    task t_flags;
        kv = {8{32'h3c5a_96e1}};
        d(zlk_pkg::ZLK_CMD_CHALLENGE, zlk_pkg::ZLK_RES_OK, 4'h7, 1'b1);
        cmp(ki, kv);
        q(9'h100, 9'h1f0);
        d(zlk_pkg::ZLK_CMD_DIGEST, zlk_pkg::ZLK_RES_OK, 4'h5, 1'b0, 1'b1);
        q(9'h1a5, 9'h1ff);
        hm = 1'b1;
        g(zlk_pkg::ZLK_CMD_MAC, 4'h5, 1'b1, 1'b0);
        hm = 1'b0;
        g(zlk_pkg::ZLK_CMD_MAC, 4'h5, 1'b1, 1'b1);
        d(zlk_pkg::ZLK_CMD_KEYGEN, zlk_pkg::ZLK_RES_OK, 4'h9);
        q(9'h1c9, 9'h1ff);
        d(zlk_pkg::ZLK_CMD_CHALLENGE);
        q(9'h110, 9'h1f0);
    endtask : t_flags
    task vc(input zlk_pkg::zlk_cmd_e c, input zlk_pkg::zlk_res_e r, input logic e);
        d(zlk_pkg::ZLK_CMD_CHALLENGE, zlk_pkg::ZLK_RES_OK, 4'h0, 1'b1);
        d(c, r, 4'h4, 1'b1);
        q({e, 8'h00}, 9'h100);
    endtask : vc
    task t_valid;
        vc(zlk_pkg::ZLK_CMD_DIGEST, zlk_pkg::ZLK_RES_ERR, 1'b0);
        vc(zlk_pkg::ZLK_CMD_DIGEST, zlk_pkg::ZLK_RES_CRC, 1'b1);
        vc(zlk_pkg::ZLK_CMD_KEYGEN, zlk_pkg::ZLK_RES_ECC_RTY, 1'b1);
        vc(zlk_pkg::ZLK_CMD_CHALLENGE, zlk_pkg::ZLK_RES_ERR, 1'b0);
        vc(zlk_pkg::ZLK_CMD_MACCHK, zlk_pkg::ZLK_RES_OK, 1'b1);
        vc(zlk_pkg::ZLK_CMD_MACCHK, zlk_pkg::ZLK_RES_ERR, 1'b0);
        vc(zlk_pkg::ZLK_CMD_STATUS, zlk_pkg::ZLK_RES_ERR, 1'b1);
        vc(zlk_pkg::ZLK_CMD_READ, zlk_pkg::ZLK_RES_OK, 1'b0);
        vc(zlk_pkg::ZLK_CMD_OTHER, zlk_pkg::ZLK_RES_CRC, 1'b1);
    endtask : t_valid
    task t_power;
        for (int i = 0; i < 4; i++)
        begin
            d(zlk_pkg::ZLK_CMD_CHALLENGE, zlk_pkg::ZLK_RES_OK, 4'h0, 1'b1);
            @(negedge clk);
            ev = 4'h1 << i;
            @(negedge clk);
            ev = 4'h0;
            if (i == 0)
                cmp(ki, 256'h0);
            q(9'h000, 9'h100);
        end
        d(zlk_pkg::ZLK_CMD_CHALLENGE, zlk_pkg::ZLK_RES_OK, 4'h0, 1'b1);
        repeat (5) @(negedge clk);
        cmp(ki, kv);
        q(9'h100, 9'h100);
    endtask : t_power
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test();
    end
    initial
    begin
        {rst_n, mwe, pwe, mwd, pwd, ev, kv, hm} = '0;
        errors = 0;
        comparisons = 0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_pre_cfg();
        t_cfg_locked();
        t_data_locked();
        t_flags();
        t_valid();
        t_power();
        finish_test();
    end
endmodule : test_zlk_zone_lock
bind zlk_zone_lock zlk_zone_lock_props #(.SLOTS(SLOTS)) u_props (.i_clk, .i_rst_n,
    .i_chk_valid, .i_chk_cmd, .i_chk_zone, .i_chk_slot, .o_grant, .i_cfg_mask_we,
    .i_cfg_mask_wdata, .i_done, .i_done_cmd, .i_done_res, .i_done_slot, .i_sleep, .i_brownout,
    .i_wdog, .i_tamper, .o_data_unlocked, .o_cfg_unlocked, .o_slot_lock_mask,
    .o_slot_lock_permit, .o_status_flags, .o_status_valid);
